// *** design/gpp_port.sv ***
// gpio port: pin data, pin interrupts, wired-or port interrupt, data bypass
// How it works
// - each pin has an interrupt enable bit at its own bit position, one enables
// - one mode bit for all pins: 0 interrupt on low, 1 on change
// - change mode: last read 0 interrupts on high, last read 1 on low
// - a disabled pin never asserts its interrupt in either mode
// - each pin drives an active-low open-drain interrupt, wire-ored to one line
// - a pin interrupt depends only on its enable and the mode condition
// - enabling a pin already meeting the condition asserts its interrupt at once
// - pin interrupt holds until disable, pin flip, change-mode read or mode change
// - port interrupt raised on new falling of wired line, released when all let go
// - a second pin holding the line hides the first pin's release
// - unread in change mode, compare stays against the stored reference latch
// - writing data bit sets output high for one, low for zero, unless bypassed
// - data reads return pin levels; other registers read back stored contents
// - an enabled internal serial function routes its own output data to its pins
// - on a four-pin port only the low four enable bits act
// - a pin in analog drive mode reads zero and cannot usefully interrupt
// - the interrupt mode selector is bit 0 of the io configuration register
//
// The placing of the registers and the Avalon-MM slave port were decided locally.
`timescale 1ns/1ps
`include "gpp_regs.svh"

module gpp_port #(
  parameter int PINS = 8
) (
  input wire logic MCLK_I,
  input wire logic SYS_RST_I,
  input wire logic [`GPP_ADDR_W-1:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  input wire logic CFG_SEL_I,
  output logic [31:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  output logic AVS_RESPONSE_ERR_O,
  input wire logic [PINS-1:0] PIN_I,
  output logic [PINS-1:0] PIN_O,
  output logic [PINS-1:0] PIN_OE_N_O,
  input wire logic [PINS-1:0] ALT_SEL_I,
  input wire logic [PINS-1:0] ALT_DATA_I,
  output logic [PINS-1:0] PIN_IRQ_N_O,
  output logic PORT_IRQ_O
);

  // registers
  logic [PINS-1:0] port_pin_data_reg;
  logic [PINS-1:0] port_irq_enable_reg;
  logic [PINS-1:0] drive_mode_low_reg;
  logic [PINS-1:0] drive_mode_high_reg;
  logic [7:0] io_config_one;
  logic [PINS-1:0] ref_latch;
  logic [PINS-1:0] pin_meta;
  logic [PINS-1:0] pin_sync;
  logic [PINS-1:0] alt_sel_meta;
  logic [PINS-1:0] alt_sel_sync;
  logic [PINS-1:0] alt_data_meta;
  logic [PINS-1:0] alt_data_sync;
  logic line_low_q;
  logic ack;

  // widens a register to the bus word; bits above the port read zero
  function automatic logic [31:0] to_word(input logic [PINS-1:0] value);
    to_word = {{(32-PINS){1'b0}}, value};
  endfunction

  function automatic gpp_pkg::gpp_drive_mode_t drive_mode_of(input logic dm1,
      input logic dm0);
    drive_mode_of = gpp_pkg::gpp_drive_mode_t'({dm1, dm0});
  endfunction

  function automatic logic drives_high(input logic dm1, input logic dm0);
    // pull-up and open drain leave the high side to the resistor or the board
    drives_high = (drive_mode_of(dm1, dm0) == gpp_pkg::GPP_DM_STRONG);
  endfunction

  function automatic logic drives_low(input logic dm1, input logic dm0);
    // analog is the only mode that lets go of both sides
    drives_low = (drive_mode_of(dm1, dm0) != gpp_pkg::GPP_DM_ANALOG);
  endfunction

  function automatic logic meets_mode(input logic mode, input logic level,
      input logic ref_level);
    if (gpp_pkg::gpp_irq_mode_t'(mode) == gpp_pkg::GPP_IRQ_LOW) begin
      meets_mode = ~level;
    end else begin
      // change mode compares with the level returned by the last data read
      meets_mode = level ^ ref_level;
    end
  endfunction

  // bus decode
  wire logic req = (AVS_READ_I | AVS_WRITE_I) & ~ack;
  // writes land at the edge where the master sees waitrequest low
  wire logic accepted = ack & (AVS_READ_I | AVS_WRITE_I);
  wire logic hit_data = ~CFG_SEL_I & (AVS_ADDRESS_I == `GPP_OFS_DATA);
  wire logic hit_ie = ~CFG_SEL_I & (AVS_ADDRESS_I == `GPP_OFS_IRQ_EN);
  wire logic hit_dm0 = ~CFG_SEL_I & (AVS_ADDRESS_I == `GPP_OFS_DM_LOW);
  wire logic hit_dm1 = ~CFG_SEL_I & (AVS_ADDRESS_I == `GPP_OFS_DM_HIGH);
  wire logic hit_cfg = CFG_SEL_I & (AVS_ADDRESS_I == `GPP_OFS_CONFIG);
  wire logic hit_any = hit_data | hit_ie | hit_dm0 | hit_dm1 | hit_cfg;
  wire logic wr_lane0 = accepted & AVS_WRITE_I & AVS_BYTEENABLE_I[0];
  wire logic wr_data = wr_lane0 & hit_data;
  wire logic wr_ie = wr_lane0 & hit_ie;
  wire logic wr_dm0 = wr_lane0 & hit_dm0;
  wire logic wr_dm1 = wr_lane0 & hit_dm1;
  wire logic wr_cfg = wr_lane0 & hit_cfg;
  wire logic [PINS-1:0] wdata = AVS_WRITEDATA_I[PINS-1:0];
  wire logic [7:0] wdata_cfg = AVS_WRITEDATA_I[7:0];
  // the reference latches follow only true data reads, once per transfer
  wire logic data_read = req & AVS_READ_I & hit_data;
  wire logic rd_take = req & AVS_READ_I;

  // per-pin decode
  wire logic irq_mode_select = io_config_one[`GPP_CFG_MODE_BIT];
  wire logic [PINS-1:0] analog_mode;
  wire logic [PINS-1:0] pin_level;
  wire logic [PINS-1:0] irq_cond;
  wire logic [PINS-1:0] enable_eff;
  wire logic [PINS-1:0] pin_irq_act;
  wire logic [PINS-1:0] drive_value;
  wire logic [PINS-1:0] drive_enable;

  for (genvar i = 0; i < PINS; i++) begin : g_pin
    // four-pin ports ignore the upper enable bits
    localparam bit enable_acts = (PINS > 4) || (i < 4);
    wire logic dm1 = drive_mode_high_reg[i];
    wire logic dm0 = drive_mode_low_reg[i];
    assign analog_mode[i] = drive_mode_of(dm1, dm0) == gpp_pkg::GPP_DM_ANALOG;
    // an analog pin has its input buffer off and reads zero
    assign pin_level[i] = pin_sync[i] & ~analog_mode[i];
    assign irq_cond[i] = meets_mode(irq_mode_select, pin_level[i], ref_latch[i]);
    assign enable_eff[i] = port_irq_enable_reg[i] & enable_acts;
    // a disabled pin stays released whatever the mode
    assign pin_irq_act[i] = enable_eff[i] & irq_cond[i];
    // an enabled serial function takes the pin over from the data register
    assign drive_value[i] = alt_sel_sync[i] ? alt_data_sync[i] : port_pin_data_reg[i];
    assign drive_enable[i] = drive_value[i] ? drives_high(dm1, dm0) : drives_low(dm1, dm0);
  end

  // wired-or of the open-drain pin interrupts
  wire logic line_low = |pin_irq_act;
  // a handover between pins keeps the line low, so no new edge appears
  wire logic line_new = line_low & ~line_low_q;
  // data reads return pin levels, every other register its stored bits
  wire logic [31:0] rd_mux =
    hit_data ? to_word(pin_level) :
    hit_ie ? to_word(port_irq_enable_reg) :
    hit_dm0 ? to_word(drive_mode_low_reg) :
    hit_dm1 ? to_word(drive_mode_high_reg) :
    hit_cfg ? {24'h000000, io_config_one} : 32'h00000000;

  // two flops on every pin before any logic looks at it
  always_ff @(posedge MCLK_I) begin
    pin_meta <= PIN_I;
    pin_sync <= pin_meta;
  end

  // select and data cross apart, so a change of both may mix for one cycle
  always_ff @(posedge MCLK_I) begin
    alt_sel_meta <= ALT_SEL_I;
    alt_sel_sync <= alt_sel_meta;
  end

  always_ff @(posedge MCLK_I) begin
    alt_data_meta <= ALT_DATA_I;
    alt_data_sync <= alt_data_meta;
  end

  // bus slave: one wait state, answer on the second cycle of the request
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      ack <= 1'b0;
    end else begin
      ack <= req;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      AVS_WAITREQUEST_O <= 1'b1;
    end else begin
      AVS_WAITREQUEST_O <= ~req;
    end
  end

  // read data stays zero outside the answer cycle
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      AVS_READDATA_O <= 32'h00000000;
    end else begin
      AVS_READDATA_O <= rd_take ? rd_mux : 32'h00000000;
    end
  end

  // an unmapped address answers with an error and zero data
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      AVS_RESPONSE_ERR_O <= 1'b0;
    end else begin
      AVS_RESPONSE_ERR_O <= req & ~hit_any;
    end
  end

  // register writes, one short process per register
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      port_pin_data_reg <= PINS'(`GPP_RST_DATA);
    end else if (wr_data) begin
      port_pin_data_reg <= wdata;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      port_irq_enable_reg <= PINS'(`GPP_RST_IRQ_EN);
    end else if (wr_ie) begin
      port_irq_enable_reg <= wdata;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      drive_mode_low_reg <= PINS'(`GPP_RST_DM_LOW);
    end else if (wr_dm0) begin
      drive_mode_low_reg <= wdata;
    end
  end

  // drive modes wake up analog, so no pin is driven or read until set
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      drive_mode_high_reg <= PINS'(`GPP_RST_DM_HIGH);
    end else if (wr_dm1) begin
      drive_mode_high_reg <= wdata;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      io_config_one <= `GPP_RST_CONFIG;
    end else if (wr_cfg) begin
      io_config_one <= wdata_cfg;
    end
  end

  // reference level: refreshed on each data read, the value returned
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      ref_latch <= '0;
    end else if (data_read) begin
      ref_latch <= pin_level;
    end
  end

  // port interrupt: edge to assert, level to release
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      line_low_q <= 1'b0;
    end else begin
      line_low_q <= line_low;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      PORT_IRQ_O <= 1'b0;
    end else if (line_new) begin
      PORT_IRQ_O <= 1'b1;
    end else if (~line_low) begin
      PORT_IRQ_O <= 1'b0;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      PIN_IRQ_N_O <= '1;
    end else begin
      PIN_IRQ_N_O <= ~pin_irq_act;
    end
  end

  // pin drivers
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      PIN_O <= '0;
    end else begin
      PIN_O <= drive_value;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      PIN_OE_N_O <= '1;
    end else begin
      PIN_OE_N_O <= ~drive_enable;
    end
  end

endmodule

// *** design/gpp_regs.svh ***
// register offsets, field positions and reset values of the gpio port
`ifndef GPP_REGS_SVH
`define GPP_REGS_SVH
`define GPP_ADDR_W 4
`define GPP_OFS_DATA 4'h0
`define GPP_OFS_IRQ_EN 4'h4
`define GPP_OFS_DM_LOW 4'h8
`define GPP_OFS_DM_HIGH 4'hc
`define GPP_OFS_CONFIG 4'h0
`define GPP_CFG_MODE_BIT 0
`define GPP_RST_DATA 8'h00
`define GPP_RST_IRQ_EN 8'h00
`define GPP_RST_DM_LOW 8'h00
`define GPP_RST_DM_HIGH 8'hff
`define GPP_RST_CONFIG 8'h00
`endif

// *** design/gpp_pkg.sv ***
// types of the gpio port
package gpp_pkg;
  typedef enum logic [1:0] {
    GPP_DM_PULLUP,
    GPP_DM_STRONG,
    GPP_DM_ANALOG,
    GPP_DM_OPEN_DRAIN
  } gpp_drive_mode_t;
  typedef enum logic {
    GPP_IRQ_LOW,
    GPP_IRQ_CHANGE
  } gpp_irq_mode_t;
endpackage

// *** verif/gpp_pins.sv ***
// board model of the port pins
`timescale 1ns/1ps
module gpp_pins #(
  parameter int PINS = 8
) (
  input wire logic [PINS-1:0] pin_o_i,
  input wire logic [PINS-1:0] oe_n_i,
  input wire logic [PINS-1:0] ext_i,
  output logic [PINS-1:0] pin_i_o
);
  // the board source yields while the port drives, so no contention is modelled
  assign pin_i_o = (~oe_n_i & pin_o_i) | (oe_n_i & ext_i);
endmodule

// *** verif/gpp_port_sva.sv ***
// port-level assertions of the gpio port
`timescale 1ns/1ps
module gpp_port_sva #(
  parameter int PINS = 8
) (
  input wire logic MCLK_I,
  input wire logic SYS_RST_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic AVS_WAITREQUEST_O,
  input wire logic AVS_RESPONSE_ERR_O,
  input wire logic [31:0] AVS_READDATA_O,
  input wire logic [PINS-1:0] PIN_I,
  input wire logic [PINS-1:0] PIN_IRQ_N_O,
  input wire logic PORT_IRQ_O
);
  logic [3:0] quiet;
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (SYS_RST_I);
  // quiet counts cycles with no pin change and no bus request
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I || AVS_READ_I || AVS_WRITE_I || PIN_I != $past(PIN_I)) quiet <= 4'h0;
    else if (quiet != 4'h6) quiet <= quiet + 4'h1;
  end
  sequence s_taken;
    (AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O;
  endsequence
  sequence s_answer;
    !AVS_WAITREQUEST_O ##1 AVS_WAITREQUEST_O;
  endsequence
  a_answer_next: assert property (s_taken |=> s_answer)
    else $error("answer not one cycle after request");
  a_idle_zero: assert property (AVS_WAITREQUEST_O |-> AVS_READDATA_O == 32'h0)
    else $error("read data not zero while idle");
  a_err_zero: assert property (AVS_RESPONSE_ERR_O |-> AVS_READDATA_O == 32'h0)
    else $error("error answer carries data");
  a_port_rise: assert property ($fell(&PIN_IRQ_N_O) |-> PORT_IRQ_O)
    else $error("port interrupt missed a new assertion");
  a_port_clear: assert property (&PIN_IRQ_N_O |-> !PORT_IRQ_O)
    else $error("port interrupt held with no pin asserting");
  a_port_hold: assert property ($past(PORT_IRQ_O) && !(&PIN_IRQ_N_O) |-> PORT_IRQ_O)
    else $error("port interrupt dropped while line low");
  a_port_cause: assert property ($rose(PORT_IRQ_O) |-> $fell(&PIN_IRQ_N_O))
    else $error("port interrupt without pin assertion");
  a_irq_quiet: assert property (quiet == 4'h6 |-> $stable(PIN_IRQ_N_O))
    else $error("pin interrupt moved with no cause");
endmodule
bind gpp_port gpp_port_sva #(.PINS(PINS)) sva (
  .MCLK_I(MCLK_I),
  .SYS_RST_I(SYS_RST_I),
  .AVS_READ_I(AVS_READ_I),
  .AVS_WRITE_I(AVS_WRITE_I),
  .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
  .AVS_RESPONSE_ERR_O(AVS_RESPONSE_ERR_O),
  .AVS_READDATA_O(AVS_READDATA_O),
  .PIN_I(PIN_I),
  .PIN_IRQ_N_O(PIN_IRQ_N_O),
  .PORT_IRQ_O(PORT_IRQ_O)
);

// *** verif/gpio_port_pin_interrupts_tb_top.sv ***
// self-checking bench of the gpio port
`timescale 1ns/1ps
module gpio_port_pin_interrupts_tb_top;
  logic clk = 0, rst = 1, rd = 0, wr = 0, cfg = 0, wreq, err, pirq;
  logic [3:0] adr = 4'h0;
  logic [31:0] wd = 32'h0, rdata;
  logic [7:0] ext = 8'hff, asel = 8'h0, adat = 8'h0, pin_i, pin_o, oe_n, irq_n, ie, rl, d;
  int n_errors = 0, checks_done = 0, mode = 0;
  always #5 clk = ~clk;
  gpp_port dut (.MCLK_I(clk), .SYS_RST_I(rst), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd),
    .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wd), .AVS_BYTEENABLE_I(4'hf), .CFG_SEL_I(cfg),
    .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(wreq), .AVS_RESPONSE_ERR_O(err),
    .PIN_I(pin_i), .PIN_O(pin_o), .PIN_OE_N_O(oe_n), .ALT_SEL_I(asel),
    .ALT_DATA_I(adat), .PIN_IRQ_N_O(irq_n), .PORT_IRQ_O(pirq));
  gpp_pins pins (.pin_o_i(pin_o), .oe_n_i(oe_n), .ext_i(ext), .pin_i_o(pin_i));
  task end_sim;
    $display("errors=%0d checks=%0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input logic [32:0] got, input logic [32:0] want);
    checks_done++;
    if (got !== want) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  // e holds the expected error bit above the expected read data
  task bus(input bit w, input bit c, input logic [3:0] a, input logic [7:0] v,
      input logic [32:0] e);
    int k;
    @(posedge clk);
    rd <= !w;
    wr <= w;
    cfg <= c;
    adr <= a;
    wd <= {24'h0, v};
    for (k = 0; wreq !== 1'b0 && k < 20; k++) @(posedge clk);
    if (k == 20) n_errors++;
    if (!w) chk({err, rdata}, e);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  // expected pin interrupts from enable, mode, pin level and reference latch
  task irqchk;
    logic [7:0] x;
    repeat (5) @(posedge clk);
    for (int i = 0; i < 8; i++) x[i] = !(ie[i] && (mode ? ext[i] != rl[i] : !ext[i]));
    chk({25'h0, irq_n}, {25'h0, x});
    chk({32'h0, pirq}, {32'h0, x != 8'hff});
  endtask
  initial begin
    void'($urandom(32'h790427a4));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    bus(0, 0, 4'h4, 8'h0, 33'h0);
    bus(0, 0, 4'h8, 8'h0, 33'h0);
    bus(0, 0, 4'hc, 8'h0, 33'h0ff);
    bus(0, 1, 4'h0, 8'h0, 33'h0);
    bus(0, 1, 4'h4, 8'h0, 33'h100000000);
    bus(0, 0, 4'h0, 8'h0, 33'h0);
    rl = 8'h0;
    bus(1, 0, 4'h8, 8'hff, 33'h0);
    bus(1, 0, 4'h0, 8'hff, 33'h0);
    repeat (20) begin
      mode = $urandom % 2;
      ie = 8'($urandom);
      bus(1, 1, 4'h0, mode[7:0], 33'h0);
      bus(1, 0, 4'h4, ie, 33'h0);
      irqchk();
      ext <= 8'($urandom);
      irqchk();
      bus(0, 0, 4'h0, 8'h0, {25'h0, ext});
      rl = ext;
      irqchk();
      bus(0, 0, 4'h4, 8'h0, {25'h0, ie});
    end
    bus(1, 0, 4'hc, 8'h0, 33'h0);
    d = 8'($urandom);
    asel <= 8'($urandom);
    adat <= 8'($urandom);
    bus(1, 0, 4'h0, d, 33'h0);
    repeat (6) @(posedge clk);
    chk({25'h0, pin_o}, {25'h0, (asel & adat) | (~asel & d)});
    chk({25'h0, oe_n}, 33'h0);
    end_sim();
  end
  initial begin
    #300000;
    n_errors++;
    end_sim();
  end
endmodule
